// file: acs_adc_dev.sv
/*
 Converter end: decodes link frames, runs the single, repeat, sweep and
 repeat sweep modes and keeps the result FIFO with its threshold.
 Assumes link pins are asynchronous to hclk and that the user side
 presents sample_value for sample_channel while conv_req is high.
*/
// How it works
// R1: Sweep halts once FIFO reaches threshold.
// R2: At threshold sweep drops conversions, keeps reads.
// R3: Repeat sweep conversion at threshold flushes FIFO, restarts order.
// R4: Host reads FIFO after threshold reached.
// R5: Repeat sweep host rereads or reconfigures freely.
// R6: Host selects channel before single/repeat conversions.
// R7: Single bypasses FIFO; repeat stores each result.
// R8: Repeat needs fresh channel select after threshold.
// R9: Repeat: depth four, mode 01, select, convert.
// R10: Sweep converts order entries, reads in order.
// R11: Repeat sweep reruns same order after readout.
// R12: Power down costs one frame, no conversion.
// R13: FIFO keeps completion order, counts against threshold.
`timescale 1ns/1ps
module acs_adc_dev #(
	parameter int FIFO_DEPTH = acs_pkg::FIFO_DEPTH
) (
	acs_link_if.dev link, // Serial link, converter side
	input wire logic hclk, // System clock
	input wire logic hresetn, // Asynchronous reset, active low
	input wire logic [acs_pkg::RES_W-1:0] sample_value, // Converted analog value
	output logic [1:0] sample_channel, // Channel being converted
	output logic conv_req, // One-cycle conversion pulse
	output logic powered_down, // Software power down active
	output logic fifo_at_threshold // FIFO filled to threshold
);
	localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	localparam int CW = $clog2(FIFO_DEPTH + 1);
	localparam int FB = acs_pkg::FRAME_BITS;
	logic [3:0] pin_raw, pin_meta_reg, pin_sync_reg, pin_prev_reg;
	logic sclk_rise, sclk_fall, cs_fall, cs_rise, cst_fall;
	assign pin_raw = {link.conversion_start_pin_n, link.sdi, link.cs_n, link.sclk};
	for (genvar gi = 0; gi < 4; gi++) begin : g_sync
		// Reset to the pin's idle level, so no false edge follows reset
		localparam logic IDLE_LVL = (gi != acs_pkg::PIN_SCLK) && (gi != acs_pkg::PIN_SDI);
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				pin_meta_reg[gi] <= IDLE_LVL;
				pin_sync_reg[gi] <= IDLE_LVL;
				pin_prev_reg[gi] <= IDLE_LVL;
			end else begin
				pin_meta_reg[gi] <= pin_raw[gi];
				pin_sync_reg[gi] <= pin_meta_reg[gi];
				pin_prev_reg[gi] <= pin_sync_reg[gi];
			end
		end
	end
	assign sclk_rise = pin_sync_reg[acs_pkg::PIN_SCLK] & ~pin_prev_reg[acs_pkg::PIN_SCLK];
	assign sclk_fall = ~pin_sync_reg[acs_pkg::PIN_SCLK] & pin_prev_reg[acs_pkg::PIN_SCLK];
	assign cs_fall = ~pin_sync_reg[acs_pkg::PIN_CS] & pin_prev_reg[acs_pkg::PIN_CS];
	assign cs_rise = pin_sync_reg[acs_pkg::PIN_CS] & ~pin_prev_reg[acs_pkg::PIN_CS];
	assign cst_fall = ~pin_sync_reg[acs_pkg::PIN_CST] & pin_prev_reg[acs_pkg::PIN_CST];
	// Frame shifter
	logic [FB-1:0] in_reg, in_next, tx_reg, tx_next, out_reg, out_next;
	logic [4:0] bcnt_reg, bcnt_next;
	logic sdo_reg, sdo_next;
	always_comb begin
		in_next = in_reg;
		tx_next = tx_reg;
		bcnt_next = bcnt_reg;
		sdo_next = sdo_reg;
		if (cs_fall) begin
			bcnt_next = 5'h00;
			tx_next = out_reg;
			sdo_next = out_reg[FB-1];
		end else if (!pin_sync_reg[acs_pkg::PIN_CS]) begin
			if (sclk_rise) begin
				in_next = {in_reg[FB-2:0], pin_sync_reg[acs_pkg::PIN_SDI]};
				if (bcnt_reg != 5'h1F) begin
					bcnt_next = bcnt_reg + 5'h01;
				end
			end
			if (sclk_fall) begin
				tx_next = {tx_reg[FB-2:0], 1'b0};
				sdo_next = tx_reg[FB-2];
			end
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			in_reg <= '0;
			tx_reg <= '0;
			bcnt_reg <= 5'h00;
			sdo_reg <= 1'b0;
		end else begin
			in_reg <= in_next;
			tx_reg <= tx_next;
			bcnt_reg <= bcnt_next;
			sdo_reg <= sdo_next;
		end
	end
	assign link.sdo = sdo_reg;
	// Sequencer and FIFO
	logic [acs_pkg::CFG_W-1:0] cfg_reg, cfg_next;
	logic [1:0] chan_reg, chan_next, cchan_reg, cchan_next, idx_reg, idx_next, conv_ch;
	logic armed_reg, armed_next, thr_reg, thr_next, pdown_reg, pdown_next, pend_reg, pend_next;
	logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
	logic [CW-1:0] cnt_reg, cnt_next, cnt_after;
	logic [FB-1:0] mem [FIFO_DEPTH];
	logic cmd_valid, is_sel, do_conv, push, pop, flush;
	logic [3:0] cmd;
	logic [2:0] thr_val;
	logic [acs_pkg::ORDER_W-1:0] order_sh;
	logic [FB-1:0] result_word;
	acs_pkg::acs_mode_t mode;
	assign cmd_valid = cs_rise && (bcnt_reg == 5'(FB));
	assign cmd = in_reg[acs_pkg::CMD_LSB +: 4];
	assign is_sel = cmd_valid && (cmd[3:2] == acs_pkg::CMD_SEL_PFX);
	assign mode = acs_pkg::acs_mode_t'(cfg_reg[acs_pkg::CFG_MODE_LSB +: 2]);
	assign thr_val = {1'b0, cfg_reg[acs_pkg::CFG_THR_LSB +: 2]} + 3'h1;
	assign order_sh = cfg_reg[acs_pkg::CFG_ORDER_LSB +: acs_pkg::ORDER_W] >> {idx_reg, 1'b0};
	assign result_word = {cchan_reg, 4'h0, sample_value};
	always_comb begin
		cfg_next = cfg_reg;
		chan_next = chan_reg;
		cchan_next = cchan_reg;
		idx_next = idx_reg;
		armed_next = armed_reg;
		thr_next = thr_reg;
		pdown_next = pdown_reg;
		wp_next = wp_reg;
		rp_next = rp_reg;
		cnt_next = cnt_reg;
		cnt_after = cnt_reg;
		out_next = out_reg;
		do_conv = 1'b0;
		conv_ch = chan_reg;
		push = 1'b0;
		pop = 1'b0;
		flush = 1'b0;
		if (pend_reg) begin
			if (mode == acs_pkg::MODE_SINGLE) begin
				out_next = result_word; // R7
			end else if (cnt_reg != CW'(FIFO_DEPTH)) begin
				push = 1'b1; // R7 R13
			end
		end
		if (cmd_valid) begin
			case (cmd)
				acs_pkg::CMD_CFG_WR: begin
					cfg_next = in_reg[acs_pkg::CFG_W-1:0];
					flush = 1'b1;
					armed_next = 1'b0;
					idx_next = 2'h0;
					pdown_next = 1'b0;
				end
				acs_pkg::CMD_CFG_RD: out_next = {4'h0, cfg_reg};
				acs_pkg::CMD_FIFO_RD: begin
					if (cnt_reg != '0) begin
						out_next = mem[rp_reg]; // R13
						pop = 1'b1;
					end else begin
						out_next = '0;
					end
				end
				acs_pkg::CMD_PDOWN: pdown_next = 1'b1; // R12
				default: ;
			endcase
		end
		// A select wakes from power down; a start pulse does not
		if (is_sel) begin
			pdown_next = 1'b0;
		end
		if ((is_sel || (cst_fall && !pdown_reg)) && !(cmd_valid && cmd == acs_pkg::CMD_CFG_WR)) begin
			case (mode)
				acs_pkg::MODE_SINGLE, acs_pkg::MODE_REPEAT: begin
					if (is_sel && !thr_reg) begin
						chan_next = cmd[1:0]; // R6 R9
						armed_next = 1'b1;
						do_conv = 1'b1;
						conv_ch = cmd[1:0];
					end else if (armed_reg && !thr_reg) begin
						do_conv = 1'b1; // R8
					end
				end
				acs_pkg::MODE_SWEEP: begin
					if (!thr_reg) begin
						do_conv = 1'b1; // R10
						conv_ch = order_sh[1:0];
						idx_next = idx_reg + 2'h1;
					end
				end
				acs_pkg::MODE_RSWEEP: begin
					if (thr_reg) begin
						flush = 1'b1; // R3
						do_conv = 1'b1;
						conv_ch = cfg_reg[acs_pkg::CFG_ORDER_LSB +: 2];
						idx_next = 2'h1;
					end else begin
						do_conv = 1'b1; // R11
						conv_ch = order_sh[1:0];
						idx_next = idx_reg + 2'h1;
					end
				end
				default: ;
			endcase
		end
		if (do_conv) begin
			cchan_next = conv_ch;
		end
		if (flush) begin
			wp_next = '0;
			rp_next = '0;
			cnt_next = '0;
			thr_next = 1'b0;
		end else begin
			if (push) begin
				wp_next = (wp_reg == PW'(FIFO_DEPTH - 1)) ? '0 : wp_reg + PW'(1);
			end
			if (pop) begin
				rp_next = (rp_reg == PW'(FIFO_DEPTH - 1)) ? '0 : rp_reg + PW'(1);
			end
			cnt_after = cnt_reg + CW'(push) - CW'(pop);
			cnt_next = cnt_after;
			if (push && (cnt_after >= CW'(thr_val))) begin
				thr_next = 1'b1; // R1 R2 R13
				idx_next = 2'h0;
				if (mode == acs_pkg::MODE_REPEAT) begin
					armed_next = 1'b0; // R8
				end
			end else if (pop && cnt_after == '0) begin
				thr_next = 1'b0; // R4
			end
		end
	end
	assign pend_next = do_conv;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_reg <= acs_pkg::CFG_RESET;
			chan_reg <= 2'h0;
			cchan_reg <= 2'h0;
			idx_reg <= 2'h0;
			armed_reg <= 1'b0;
			thr_reg <= 1'b0;
			pdown_reg <= 1'b0;
			pend_reg <= 1'b0;
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
			out_reg <= '0;
		end else begin
			cfg_reg <= cfg_next;
			chan_reg <= chan_next;
			cchan_reg <= cchan_next;
			idx_reg <= idx_next;
			armed_reg <= armed_next;
			thr_reg <= thr_next;
			pdown_reg <= pdown_next;
			pend_reg <= pend_next;
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			cnt_reg <= cnt_next;
			out_reg <= out_next;
		end
	end
	// Memory needs no reset; count guards every read
	always_ff @(posedge hclk) begin
		if (push && !flush) begin
			mem[wp_reg] <= result_word;
		end
	end
	assign sample_channel = cchan_reg;
	assign conv_req = pend_reg;
	assign powered_down = pdown_reg;
	assign fifo_at_threshold = thr_reg;
endmodule

// file: acs_host_ctl.sv
/*
 Host end: AHB-Lite register slave that sends one 16-bit frame per
 command write and pulses the conversion start pin on request.
 Assumes a single AHB master, word transfers only, and the converter
 end on the far side of the link interface.
*/
`timescale 1ns/1ps
module acs_host_ctl (
	acs_link_if.host link, // Serial link, host side
	input wire logic hclk, // System clock
	input wire logic hresetn, // Asynchronous reset, active low
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write strobe
	input wire logic [2:0] hsize, // Transfer size
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic hreadyout, // Always ready
	output logic hresp, // Always OKAY
	output logic [31:0] hrdata, // Read data
	output logic irq // Level interrupt
);
	localparam int FB = acs_pkg::FRAME_BITS;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FRAME = 2'b01,
		ST_GAP = 2'b10,
		ST_STROBE = 2'b11
	} acs_hstate_t;

	acs_hstate_t st_reg, st_next;
	logic [3:0] tick_reg, tick_next;
	logic [5:0] half_reg, half_next;
	logic sclk_reg, sclk_next;
	logic cs_n_reg, cs_n_next;
	logic cst_n_reg, cst_n_next;
	logic [FB-1:0] tx_reg, tx_next;
	logic [FB-1:0] rx_reg, rx_next;
	logic [FB-1:0] rxd_reg, rxd_next;
	logic [acs_pkg::INT_W-1:0] ist_reg, ist_next;
	logic [acs_pkg::INT_W-1:0] imask_reg, imask_next;
	logic wr_reg, wr_next;
	logic [7:0] wa_reg, wa_next;
	logic [31:0] rd_reg, rd_next;
	logic sdo_meta_reg;
	logic sdo_sync_reg;
	logic tick_end;
	logic [acs_pkg::INT_W-1:0] ev;

	assign tick_end = (tick_reg == 4'(acs_pkg::SCLK_HALF_CYC - 1));

	always_comb begin
		st_next = st_reg;
		tick_next = tick_reg;
		half_next = half_reg;
		sclk_next = sclk_reg;
		cs_n_next = cs_n_reg;
		cst_n_next = cst_n_reg;
		tx_next = tx_reg;
		rx_next = rx_reg;
		rxd_next = rxd_reg;
		imask_next = imask_reg;
		ev = '0;
		wr_next = hsel && htrans[1] && hready && hwrite;
		wa_next = haddr[7:0];
		rd_next = rd_reg;
		if (hsel && htrans[1] && hready && !hwrite) begin
			case (haddr[7:0])
				acs_pkg::REG_STATUS: rd_next = {31'h0, st_reg != ST_IDLE};
				acs_pkg::REG_RX: rd_next = {16'h0, rxd_reg};
				acs_pkg::REG_INT_STAT: rd_next = {30'h0, ist_reg};
				acs_pkg::REG_INT_MASK: rd_next = {30'h0, imask_reg};
				default: rd_next = 32'h0000_0000;
			endcase
		end
		case (st_reg)
			ST_IDLE: begin
				tick_next = 4'h0;
				half_next = 6'h00;
				if (wr_reg && wa_reg == acs_pkg::REG_CMD) begin
					tx_next = hwdata[FB-1:0];
					cs_n_next = 1'b0;
					st_next = ST_FRAME;
				end else if (wr_reg && wa_reg == acs_pkg::REG_CONVERSION_START_PIN && hwdata[0]) begin
					cst_n_next = 1'b0;
					st_next = ST_STROBE;
				end
			end
			ST_FRAME: begin
				tick_next = tick_end ? 4'h0 : tick_reg + 4'h1;
				if (tick_end) begin
					half_next = half_reg + 6'h01;
					sclk_next = !sclk_reg;
					if (sclk_reg) begin
						// Sample before shifting: sdo has settled a full half period
						rx_next = {rx_reg[FB-2:0], sdo_sync_reg};
						tx_next = {tx_reg[FB-2:0], 1'b0};
					end
					if (half_reg == 6'(2 * FB - 1)) begin
						cs_n_next = 1'b1;
						half_next = 6'h00;
						st_next = ST_GAP;
					end
				end
			end
			ST_GAP: begin
				tick_next = tick_end ? 4'h0 : tick_reg + 4'h1;
				if (tick_end) begin
					half_next = half_reg + 6'h01;
					if (half_reg == 6'(acs_pkg::GAP_HALVES - 1)) begin
						rxd_next = rx_reg; // R4
						ev[acs_pkg::INT_FRAME_BIT] = 1'b1;
						st_next = ST_IDLE;
					end
				end
			end
			ST_STROBE: begin
				tick_next = tick_reg + 4'h1;
				if (tick_reg == 4'(acs_pkg::CONVERSION_START_PIN_LOW_CYC - 1)) begin
					cst_n_next = 1'b1;
					ev[acs_pkg::INT_CST_BIT] = 1'b1;
					st_next = ST_IDLE;
				end
			end
			default: st_next = ST_IDLE;
		endcase
		if (wr_reg && wa_reg == acs_pkg::REG_INT_MASK) begin
			imask_next = hwdata[acs_pkg::INT_W-1:0];
		end
		// New events win over a same-cycle write-one-to-clear
		ist_next = ist_reg;
		if (wr_reg && wa_reg == acs_pkg::REG_INT_STAT) begin
			ist_next = ist_reg & ~hwdata[acs_pkg::INT_W-1:0];
		end
		ist_next = ist_next | ev;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= ST_IDLE;
			tick_reg <= 4'h0;
			half_reg <= 6'h00;
			sclk_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			cst_n_reg <= 1'b1;
			tx_reg <= '0;
			rx_reg <= '0;
			rxd_reg <= '0;
			ist_reg <= '0;
			imask_reg <= '0;
			wr_reg <= 1'b0;
			wa_reg <= 8'h00;
			rd_reg <= 32'h0000_0000;
			sdo_meta_reg <= 1'b0;
			sdo_sync_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			tick_reg <= tick_next;
			half_reg <= half_next;
			sclk_reg <= sclk_next;
			cs_n_reg <= cs_n_next;
			cst_n_reg <= cst_n_next;
			tx_reg <= tx_next;
			rx_reg <= rx_next;
			rxd_reg <= rxd_next;
			ist_reg <= ist_next;
			imask_reg <= imask_next;
			wr_reg <= wr_next;
			wa_reg <= wa_next;
			rd_reg <= rd_next;
			sdo_meta_reg <= link.sdo;
			sdo_sync_reg <= sdo_meta_reg;
		end
	end

	assign link.sclk = sclk_reg;
	assign link.cs_n = cs_n_reg;
	assign link.sdi = tx_reg[FB-1];
	assign link.conversion_start_pin_n = cst_n_reg;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rd_reg;
	assign irq = |(ist_reg & imask_reg);
endmodule

// file: acs_link_if.sv
/*
 Serial link between host controller and converter.
 Assumes the bench connects both modports; all wires are one-way.
*/
`timescale 1ns/1ps
interface acs_link_if;
	logic sclk;
	logic cs_n;
	logic sdi;
	logic sdo;
	logic conversion_start_pin_n;
	modport dev(input sclk, input cs_n, input sdi, input conversion_start_pin_n, output sdo);
	modport host(output sclk, output cs_n, output sdi, output conversion_start_pin_n, input sdo);
endinterface

// file: acs_link_sva.sv
/*
 Checker for the serial link between host controller and converter,
 watching the link wires and the converter's conversion outputs.
 Assumes it is instantiated beside the link interface in the bench.
*/
`timescale 1ns/1ps
module acs_link_sva (
	input wire logic hclk, // System clock
	input wire logic hresetn, // Asynchronous reset, active low
	input wire logic sclk, // Link clock
	input wire logic cs_n, // Frame select, active low
	input wire logic sdi, // Host to converter data
	input wire logic sdo, // Converter to host data
	input wire logic conversion_start_pin_n, // Start pulse, active low
	input wire logic conv_req, // Conversion pulse
	input wire logic fifo_at_threshold // FIFO filled to threshold
);
	logic cs_prev_reg, cs_prev_next, pin_prev_reg, pin_prev_next, sclk_prev_reg, sclk_prev_next;
	logic [3:0] age_reg, age_next;
	logic [4:0] rise_reg, rise_next;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Age saturates so a stale trigger can never excuse a later conversion
	always_comb begin
		cs_prev_next = cs_n;
		pin_prev_next = conversion_start_pin_n;
		sclk_prev_next = sclk;
		age_next = (age_reg == 4'hF) ? age_reg : age_reg + 4'h1;
		if ((cs_n && !cs_prev_reg) || (!conversion_start_pin_n && pin_prev_reg)) age_next = 4'h0;
		rise_next = rise_reg;
		if (!cs_n && cs_prev_reg) rise_next = 5'h00;
		else if (sclk && !sclk_prev_reg) rise_next = rise_reg + 5'h01;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cs_prev_reg <= 1'b1;
			pin_prev_reg <= 1'b1;
			sclk_prev_reg <= 1'b0;
			age_reg <= 4'hF;
			rise_reg <= 5'h00;
		end else begin
			cs_prev_reg <= cs_prev_next;
			pin_prev_reg <= pin_prev_next;
			sclk_prev_reg <= sclk_prev_next;
			age_reg <= age_next;
			rise_reg <= rise_next;
		end
	end
	a_sclk_idle_low: assert property (cs_n |-> !sclk)
		else $error("link clock active outside a frame");
	a_sclk_half_len: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
		else $error("link clock high phase not four cycles");
	a_frame_bit_count: assert property ($rose(cs_n) |-> rise_reg == 5'h10)
		else $error("frame closed without sixteen clock rises");
	a_sdi_hold_high: assert property (sclk && $past(sclk) |-> $stable(sdi))
		else $error("host data moved while link clock high");
	a_start_pulse_len: assert property ($fell(conversion_start_pin_n) |->
		!conversion_start_pin_n[*8] ##1 conversion_start_pin_n)
		else $error("start pulse not eight cycles low");
	a_conv_has_cause: assert property (conv_req |-> age_reg <= 4'h9)
		else $error("conversion without a recent trigger");
	a_conv_one_cycle: assert property (conv_req |=> !conv_req)
		else $error("conversion pulse longer than one cycle");
	a_thr_from_conv: assert property ($rose(fifo_at_threshold) |->
		$past(conv_req) || $past(conv_req, 2))
		else $error("threshold reached without a stored result");
	a_thr_drop_idle: assert property ($fell(fifo_at_threshold) |-> cs_n)
		else $error("threshold cleared inside a frame");
	cover property ($rose(fifo_at_threshold));
	cover property (conv_req && fifo_at_threshold);
	cover property ($fell(conversion_start_pin_n));
endmodule

// file: acs_pkg.sv
/*
 Shared constants for the ADC conversion mode sequencer: command codes,
 configuration word layout, modes, pin order and host controller map.
 Assumes both link ends and the bench agree on these values.
*/
package acs_pkg;
	localparam int FRAME_BITS = 16;
	localparam int FIFO_DEPTH = 4;
	localparam int CMD_LSB = 12;
	localparam int CFG_W = 12;
	localparam int RES_W = 10;
	// Command codes in the top nibble of a frame
	localparam logic [1:0] CMD_SEL_PFX = 2'h0;
	localparam logic [3:0] CMD_CFG_RD = 4'h8;
	localparam logic [3:0] CMD_FIFO_RD = 4'h9;
	localparam logic [3:0] CMD_CFG_WR = 4'hA;
	localparam logic [3:0] CMD_PDOWN = 4'hF;
	// Configuration word fields
	localparam int CFG_MODE_LSB = 10;
	localparam int CFG_THR_LSB = 8;
	localparam int CFG_ORDER_LSB = 0;
	localparam int ORDER_W = 8;
	localparam logic [CFG_W-1:0] CFG_RESET = 12'h000;
	typedef enum logic [1:0] {
		MODE_SINGLE = 2'b00,
		MODE_REPEAT = 2'b01,
		MODE_SWEEP = 2'b10,
		MODE_RSWEEP = 2'b11
	} acs_mode_t;
	// Synchronised pin order inside the device
	localparam int PIN_SCLK = 0;
	localparam int PIN_CS = 1;
	localparam int PIN_SDI = 2;
	localparam int PIN_CST = 3;
	// Host timing
	localparam int HCLK_PERIOD_NS = 40;
	localparam int SCLK_PERIOD_NS = 320;
	localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * HCLK_PERIOD_NS);
	localparam int GAP_HALVES = 4;
	localparam int CONVERSION_START_PIN_LOW_CYC = 8;
	// Host register map and bits
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_RX = 8'h08;
	localparam logic [7:0] REG_INT_STAT = 8'h0C;
	localparam logic [7:0] REG_INT_MASK = 8'h10;
	localparam logic [7:0] REG_CONVERSION_START_PIN = 8'h14;
	localparam int INT_FRAME_BIT = 0;
	localparam int INT_CST_BIT = 1;
	localparam int INT_W = 2;
endpackage

// file: acs_tb_top.sv
/*
 Bench joining host controller and converter over the link interface,
 driving the AHB side and judging conversions, FIFO order and replies.
 Assumes the package map and frame codes of the two ends.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module acs_tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, irq, conv_req, powered_down, fifo_at_threshold;
	logic [31:0] hrdata;
	logic [1:0] sample_channel;
	logic [7:0] conv_cnt = 8'h00;
	logic [9:0] sample_value;
	int errors = 0;
	int checked = 0;
	acs_link_if link();
	acs_host_ctl u_acs_host_ctl(.link(link), .hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));
	acs_adc_dev u_acs_adc_dev(.link(link), .hclk(hclk), .hresetn(hresetn),
		.sample_value(sample_value), .sample_channel(sample_channel), .conv_req(conv_req),
		.powered_down(powered_down), .fifo_at_threshold(fifo_at_threshold));
	acs_link_sva u_acs_link_sva(.hclk(hclk), .hresetn(hresetn), .sclk(link.sclk),
		.cs_n(link.cs_n), .sdi(link.sdi), .sdo(link.sdo),
		.conversion_start_pin_n(link.conversion_start_pin_n), .conv_req(conv_req),
		.fifo_at_threshold(fifo_at_threshold));
	// Each result carries its channel and a running count, so order slips show up
	assign sample_value = {sample_channel, conv_cnt};
	always #20 hclk = ~hclk;
	always @(posedge hclk) if (conv_req) conv_cnt <= conv_cnt + 8'h01;
	function automatic logic [15:0] res(input logic [1:0] ch, input logic [7:0] c);
		return {ch, 4'h0, ch, c};
	endfunction
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask
	task automatic idle();
		logic [31:0] r;
		r = 32'h1;
		while (r[0] !== 1'b0) ahb(1'b0, acs_pkg::REG_STATUS, 32'h0, r);
	endtask
	task automatic frame(input logic [15:0] w, output logic [15:0] rx);
		logic [31:0] r;
		ahb(1'b1, acs_pkg::REG_CMD, {16'h0, w}, r);
		idle();
		ahb(1'b0, acs_pkg::REG_RX, 32'h0, r);
		rx = r[15:0];
	endtask
	task automatic pulse(input int k);
		logic [31:0] r;
		repeat (k) begin
			ahb(1'b1, acs_pkg::REG_CONVERSION_START_PIN, 32'h1, r);
			idle();
		end
	endtask
	task automatic cfg(input logic [1:0] m, input logic [7:0] o);
		logic [15:0] rx;
		frame({acs_pkg::CMD_CFG_WR, m, 2'h3, o}, rx);
	endtask
	// Reply to each read arrives one frame late, so a config read closes the run
	task automatic rd_fifo(input logic [7:0] ord, input logic [7:0] c0);
		logic [15:0] rx;
		frame({acs_pkg::CMD_FIFO_RD, 12'h0}, rx);
		for (int i = 0; i < 4; i++) begin
			frame({(i < 3) ? acs_pkg::CMD_FIFO_RD : acs_pkg::CMD_CFG_RD, 12'h0}, rx);
			`CHK("fifo result", res(ord[2*i +: 2], c0 + 8'(i)), rx)
		end
	endtask
	task automatic t_base();
		logic [31:0] r;
		logic [15:0] rx;
		`CHK("cs_n idle", 1'b1, link.cs_n)
		`CHK("irq idle", 1'b0, irq)
		`CHK("hresp okay", 1'b0, hresp)
		ahb(1'b0, 8'h40, 32'h0, r);
		`CHK("unmapped read", 32'h0, r)
		ahb(1'b1, acs_pkg::REG_INT_MASK, 32'h1, r);
		frame({acs_pkg::CMD_CFG_RD, 12'h0}, rx);
		`CHK("irq raised", 1'b1, irq)
		ahb(1'b1, acs_pkg::REG_INT_STAT, 32'h3, r);
		@(posedge hclk);
		`CHK("irq cleared", 1'b0, irq)
		ahb(1'b1, acs_pkg::REG_INT_MASK, 32'h0, r);
		frame({acs_pkg::CMD_CFG_RD, 12'h0}, rx);
		`CHK("irq masked", 1'b0, irq)
		ahb(1'b0, acs_pkg::REG_INT_STAT, 32'h0, r);
		`CHK("status sticky", 1'b1, r[acs_pkg::INT_FRAME_BIT])
	endtask
	task automatic t_single();
		logic [7:0] n;
		logic [15:0] rx;
		cfg(2'b00, 8'h00);
		n = conv_cnt;
		pulse(1);
		`CHK("start before select", n, conv_cnt)
		frame({2'b00, 2'h2, 12'h000}, rx);
		frame({acs_pkg::CMD_FIFO_RD, 12'h0}, rx);
		`CHK("single result", res(2'h2, n), rx)
		`CHK("single no fifo", 1'b0, fifo_at_threshold)
		frame({acs_pkg::CMD_CFG_RD, 12'h0}, rx);
		`CHK("fifo empty", 16'h0000, rx)
	endtask
	task automatic t_repeat();
		logic [7:0] n;
		logic [15:0] rx;
		cfg(2'b01, 8'h00);
		n = conv_cnt;
		frame({2'b00, 2'h1, 12'h000}, rx);
		pulse(3);
		`CHK("repeat count", n + 8'h04, conv_cnt)
		`CHK("repeat full", 1'b1, fifo_at_threshold)
		pulse(1);
		frame({2'b00, 2'h1, 12'h000}, rx);
		`CHK("repeat held", n + 8'h04, conv_cnt)
		rd_fifo(8'h55, n);
		`CHK("drained", 1'b0, fifo_at_threshold)
		pulse(1);
		`CHK("needs select", n + 8'h04, conv_cnt)
		frame({2'b00, 2'h1, 12'h000}, rx);
		`CHK("select resumes", n + 8'h05, conv_cnt)
	endtask
	task automatic t_sweep();
		logic [7:0] n;
		logic [15:0] rx;
		cfg(2'b10, 8'h87);
		n = conv_cnt;
		pulse(5);
		frame({2'b00, 2'h0, 12'h000}, rx);
		`CHK("sweep stops", n + 8'h04, conv_cnt)
		`CHK("sweep full", 1'b1, fifo_at_threshold)
		frame({acs_pkg::CMD_CFG_RD, 12'h0}, rx);
		frame({acs_pkg::CMD_CFG_RD, 12'h0}, rx);
		`CHK("cfg read at full", 16'h0B87, rx)
		rd_fifo(8'h87, n);
		pulse(1);
		`CHK("sweep reuse", 2'h3, sample_channel)
		`CHK("sweep reuse cnt", n + 8'h05, conv_cnt)
	endtask
	task automatic t_rsweep();
		logic [7:0] n;
		cfg(2'b11, 8'h87);
		n = conv_cnt;
		pulse(5);
		`CHK("flush restarts", 2'h3, sample_channel)
		`CHK("flush clears", 1'b0, fifo_at_threshold)
		pulse(3);
		rd_fifo(8'h87, n + 8'h04);
		pulse(1);
		`CHK("order again", 2'h3, sample_channel)
		`CHK("order cnt", n + 8'h09, conv_cnt)
		pulse(3);
		`CHK("full again", 1'b1, fifo_at_threshold)
		cfg(2'b11, 8'h87);
		`CHK("reconfig drops", 1'b0, fifo_at_threshold)
	endtask
	task automatic t_pdown();
		logic [7:0] n;
		logic [15:0] rx;
		cfg(2'b00, 8'h00);
		// Arm the channel first, so only power down can hold back the start pulse
		frame({2'b00, 2'h2, 12'h000}, rx);
		n = conv_cnt;
		frame({acs_pkg::CMD_PDOWN, 12'h0}, rx);
		`CHK("pdown frame", n, conv_cnt)
		pulse(1);
		`CHK("pdown no conv", n, conv_cnt)
		`CHK("pdown on", 1'b1, powered_down)
		frame({2'b00, 2'h2, 12'h000}, rx);
		`CHK("select wakes", 1'b0, powered_down)
		`CHK("wake conv", n + 8'h01, conv_cnt)
	endtask
	task automatic finish_test();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_base();
		t_single();
		t_repeat();
		t_sweep();
		t_rsweep();
		t_pdown();
		finish_test();
	end
	// About thirty-five frames of some 150 cycles each fit well inside this span
	initial begin
		#2400000;
		errors++;
		finish_test();
	end
endmodule
